// ### design/autoneg_rx_arb.sv
// How it works
// RL1 - Flag a short pulse when two transitions are under 1.6 ns apart.
// RL2 - Short pulse during delimiter detect sends the receiver back to idle.
// RL3 - Short pulse in any other receive state is ignored.
// RL4 - Delimiter pair needs three transitions spaced 12.8 ns within 200 ps.
// RL5 - Delimiter pair moves idle, clock and data-one states to delimiter detect; delimiter detect stays there.
// RL6 - Page behind a bad first delimiter is dropped, no acknowledge.
// RL7 - Short-pulse page outside delimiter detect still leads to acknowledge.
// RL8 - Entering complete acknowledge latches partner next-page bit.
// RL9 - Pages keep flowing until both next-page bits are zero.
// RL10 - Keep local toggle equal to the toggle bit sent.
// RL11 - First next page toggle is inverse of base page bit eleven.
// RL12 - Each later next page inverts the previous toggle.
// RL13 - Keep received toggle equal to partner's toggle bit.
// RL14 - Wrong partner toggle withholds acknowledge, stay in next-page wait.
// RL15 - Proper toggles finish the exchange, then link signaling starts.
// RL16 - Single link ready: receiver quiet and exactly one legacy link ok.
// RL17 - Sustained single link ready moves arbitration to good check.
// RL18 - Brief legacy signaling: fault, back to ability detect, pages restart.
// RL19 - Long pulse over 20 ns aborts delimiter detect, else ignored.
// RL20 - Ability match needs three consistent pages, acknowledge bit ignored.
// RL21 - Received toggle loads from the matched ability page, then from each next page after it passes the toggle compare.
//
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module autoneg_rx_arb
	import autoneg_pkg::*;
#(
	parameter int unsigned LINK_HOLD_CYCLES = 10000
) (
	input  wire logic                        clock,
	input  wire logic                        nrst,
	input  wire logic                        edge_valid,
	input  wire logic [autoneg_pkg::GAP_W-1:0] edge_gap_ps,
	input  wire logic                        tx_page_done,
	input  wire logic                        legacy_1g_link_ok,
	input  wire logic                        legacy_10g_link_ok,
	input  wire logic [7:0]                  s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	input  wire logic [7:0]                  s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	output logic                             ack_bit_q,
	output logic                             toggle_tx_q,
	output logic                             page_tx_enable_q,
	output logic                             link_signaling_q
);
	import autoneg_pkg::*;

	logic                 c_ev, c_short, c_long, c_half, c_full, c_pair;
	rx_state_t            rx_q;
	arb_state_t           arb_q, arb_d;
	logic [PAGE_BITS-1:0] shift_q, rx_page_q, m_page;
	logic [5:0]           bit_cnt_q;
	logic                 page_valid_q, m_evt, page_receiver_quiet;
	logic                 short_pulse_q, long_pulse_q, delimiter_pair_seen_q;
	logic                 partner_next_page_latch_q, toggle_rx_q;
	logic                 single_link_ready_q, first_np_q, toggle_ok;
	logic [3:0]           acks_q;
	logic [31:0]          hold_q;
	logic [31:0]          local_lo_q;
	logic [15:0]          local_hi_q;
	logic [PAGE_BITS-1:0] local_page;
	logic                 aw_have_q, w_have_q;
	logic [7:0]           aw_addr_q;
	logic [31:0]          w_data_q;
	logic [3:0]           w_strb_q;

	edge_classifier u_class (
		.clock       (clock),
		.nrst        (nrst),
		.edge_valid  (edge_valid),
		.edge_gap_ps (edge_gap_ps),
		.ev_q        (c_ev),
		.short_q     (c_short),
		.long_q      (c_long),
		.half_q      (c_half),
		.full_q      (c_full),
		.pair_q      (c_pair)
	);

	page_matcher #(.BITS(PAGE_BITS)) u_match (
		.clock      (clock),
		.nrst       (nrst),
		.page_valid (page_valid_q),
		.page       (rx_page_q),
		.match_q    (m_evt),
		.page_q     (m_page)
	);

	// ----------------------------------------
	// Pulse flags
	// ----------------------------------------
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			short_pulse_q         <= 1'b0;
			long_pulse_q          <= 1'b0;
			delimiter_pair_seen_q <= 1'b0;
		end else begin
			if (c_ev) begin
				short_pulse_q <= c_short; // RL1
				long_pulse_q  <= c_long; // RL19
			end
			delimiter_pair_seen_q <= c_ev && c_pair; // RL4
		end
	end

	// ----------------------------------------
	// Receive machine
	// ----------------------------------------
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rx_q         <= RX_IDLE;
			shift_q      <= '0;
			rx_page_q    <= '0;
			bit_cnt_q    <= 6'h00;
			page_valid_q <= 1'b0;
		end else begin
			page_valid_q <= 1'b0;
			if (c_ev) begin
				case (rx_q)
					RX_IDLE: begin
						if (c_pair) begin
							rx_q <= RX_DELIM; // RL5 RL6
						end
					end
					RX_DELIM: begin
						if (c_short || c_long) begin
							rx_q <= RX_IDLE; // RL2 RL19
						end else if (c_pair) begin
							rx_q <= RX_DELIM; // RL5
						end else if (c_half || c_full) begin
							rx_q      <= RX_CLOCK;
							bit_cnt_q <= 6'h00;
						end
					end
					RX_CLOCK, RX_DATA1: begin
						if (c_short || c_long) begin
							rx_q <= rx_q; // RL3 RL7 RL19
						end else if (c_pair) begin
							rx_q <= RX_DELIM; // RL5
							if (bit_cnt_q >= 6'(PAGE_BITS)) begin
								rx_page_q    <= shift_q;
								page_valid_q <= 1'b1;
							end
						end else if (rx_q == RX_CLOCK && c_half) begin
							rx_q <= RX_DATA1;
						end else if (c_half || c_full) begin
							rx_q <= RX_CLOCK;
							if (bit_cnt_q < 6'(PAGE_BITS)) begin
								shift_q[bit_cnt_q] <= rx_q == RX_DATA1;
								bit_cnt_q          <= bit_cnt_q + 6'h01;
							end
						end
					end
					default: rx_q <= RX_IDLE;
				endcase
			end
		end
	end

	assign page_receiver_quiet = rx_q == RX_IDLE;
	assign local_page          = {local_hi_q, local_lo_q};
	assign toggle_ok           = m_page[TOGGLE_POS] != toggle_rx_q;

	// ----------------------------------------
	// Arbitration next state
	// ----------------------------------------
	always_comb begin
		arb_d = arb_q;
		case (arb_q)
			AR_ABILITY: begin
				if (legacy_1g_link_ok || legacy_10g_link_ok) begin
					arb_d = AR_LINK_CHECK;
				end else if (m_evt) begin
					arb_d = AR_ACK_DETECT; // RL20 RL7
				end
			end
			AR_ACK_DETECT: begin
				if (m_evt && m_page[ACK_POS]) begin
					arb_d = AR_COMPLETE_ACK;
				end
			end
			AR_COMPLETE_ACK: begin
				if (tx_page_done && acks_q + 4'h1 >= ACK_PAGES) begin
					if (local_page[NP_POS] || partner_next_page_latch_q) begin
						arb_d = AR_NEXT_WAIT; // RL9
					end else begin
						arb_d = AR_GOOD_CHECK; // RL15
					end
				end
			end
			AR_NEXT_WAIT: begin
				if (m_evt && toggle_ok) begin
					arb_d = AR_ACK_DETECT; // RL14
				end
			end
			AR_LINK_CHECK: begin
				if (!(legacy_1g_link_ok || legacy_10g_link_ok)) begin
					arb_d = AR_PD_FAULT; // RL18
				end else if (hold_q >= LINK_HOLD_CYCLES - 1) begin
					arb_d = AR_GOOD_CHECK; // RL17
				end
			end
			AR_PD_FAULT: arb_d = AR_ABILITY; // RL18
			AR_GOOD_CHECK: arb_d = AR_GOOD_CHECK;
			default: arb_d = AR_ABILITY;
		endcase
	end

	// ----------------------------------------
	// Arbitration state and flags
	// ----------------------------------------
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			arb_q                     <= AR_ABILITY;
			acks_q                    <= 4'h0;
			hold_q                    <= 32'h0000_0000;
			partner_next_page_latch_q <= 1'b0;
			toggle_rx_q               <= 1'b0;
			toggle_tx_q               <= 1'b0;
			first_np_q                <= 1'b1;
			single_link_ready_q       <= 1'b0;
			ack_bit_q                 <= 1'b0;
			page_tx_enable_q          <= 1'b0;
			link_signaling_q          <= 1'b0;
		end else begin
			arb_q <= arb_d;
			single_link_ready_q <= page_receiver_quiet &&
				(legacy_1g_link_ok ^ legacy_10g_link_ok); // RL16
			if (arb_q == AR_LINK_CHECK && single_link_ready_q) begin
				hold_q <= hold_q + 32'h0000_0001; // RL17
			end else begin
				hold_q <= 32'h0000_0000; // RL18
			end
			if (arb_q == AR_COMPLETE_ACK && tx_page_done) begin
				acks_q <= acks_q + 4'h1;
			end else if (arb_q != AR_COMPLETE_ACK) begin
				acks_q <= 4'h0;
			end
			if (arb_q != AR_COMPLETE_ACK && arb_d == AR_COMPLETE_ACK) begin
				partner_next_page_latch_q <= m_page[NP_POS]; // RL8
			end
			if (arb_q == AR_ABILITY && m_evt) begin
				toggle_rx_q <= m_page[TOGGLE_POS]; // RL13 RL21
			end else if (arb_q == AR_NEXT_WAIT && m_evt && toggle_ok) begin
				toggle_rx_q <= m_page[TOGGLE_POS]; // RL13 RL21
			end
			if (arb_q != AR_NEXT_WAIT && arb_d == AR_NEXT_WAIT) begin
				first_np_q <= 1'b0;
				if (first_np_q) begin
					toggle_tx_q <= ~local_page[TOGGLE_POS]; // RL10 RL11
				end else begin
					toggle_tx_q <= ~toggle_tx_q; // RL10 RL12
				end
			end
			if (arb_d == AR_ABILITY) begin
				first_np_q <= 1'b1;
			end
			ack_bit_q <= arb_d == AR_ACK_DETECT ||
				arb_d == AR_COMPLETE_ACK; // RL14
			page_tx_enable_q <= arb_d == AR_ABILITY ||
				arb_d == AR_ACK_DETECT || arb_d == AR_COMPLETE_ACK ||
				arb_d == AR_NEXT_WAIT; // RL18
			link_signaling_q <= arb_d == AR_GOOD_CHECK; // RL15
		end
	end

	// ----------------------------------------
	// AXI4-Lite write
	// ----------------------------------------
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			aw_have_q     <= 1'b0;
			w_have_q      <= 1'b0;
			aw_addr_q     <= 8'h00;
			w_data_q      <= 32'h0000_0000;
			w_strb_q      <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			local_lo_q    <= LOCAL_LO_RST;
			local_hi_q    <= LOCAL_HI_RST;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q     <= 1'b1;
				aw_addr_q     <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q     <= 1'b1;
				w_data_q     <= s_axi_wdata;
				w_strb_q     <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (aw_have_q && w_have_q && !s_axi_bvalid) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= RESP_OKAY;
				aw_have_q    <= 1'b0;
				w_have_q     <= 1'b0;
				if (aw_addr_q == OFS_LOCAL_LO) begin
					for (int i = 0; i < 4; i++) begin
						if (w_strb_q[i]) begin
							local_lo_q[i*8 +: 8] <= w_data_q[i*8 +: 8];
						end
					end
				end else if (aw_addr_q == OFS_LOCAL_HI) begin
					for (int i = 0; i < 2; i++) begin
						if (w_strb_q[i]) begin
							local_hi_q[i*8 +: 8] <= w_data_q[i*8 +: 8];
						end
					end
				end else begin
					s_axi_bresp <= RESP_SLVERR;
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// AXI4-Lite read
	// ----------------------------------------
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= RESP_OKAY;
				case (s_axi_araddr)
					OFS_LOCAL_LO: s_axi_rdata <= local_lo_q;
					OFS_LOCAL_HI: s_axi_rdata <= {16'h0000, local_hi_q};
					OFS_STATUS: s_axi_rdata <= {19'h00000, arb_q, rx_q,
						single_link_ready_q, toggle_rx_q, toggle_tx_q,
						partner_next_page_latch_q, ack_bit_q,
						delimiter_pair_seen_q, long_pulse_q, short_pulse_q};
					OFS_RX_LO: s_axi_rdata <= m_page[31:0];
					OFS_RX_HI: s_axi_rdata <= {16'h0000, m_page[47:32]};
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= RESP_SLVERR;
					end
				endcase
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	sequence s_short_edge;
		edge_valid && edge_gap_ps < SHORT_PS;
	endsequence
	sequence s_in_delim;
		c_ev && rx_q == RX_DELIM;
	endsequence

	a_short_flag_set: assert property (s_short_edge |-> ##2 short_pulse_q) // RL1
		else $error("short pulse flag missing");
	a_short_abort_delim: assert property (s_in_delim and c_short |=> // RL2
		rx_q == RX_IDLE) else $error("short pulse did not abort");
	a_short_ignored: assert property (c_ev && c_short && // RL3
		rx_q inside {RX_CLOCK, RX_DATA1} |=> rx_q == $past(rx_q))
		else $error("short pulse not ignored");
	a_long_abort_delim: assert property (s_in_delim and c_long |=> // RL19
		rx_q == RX_IDLE) else $error("long pulse did not abort");
	a_pair_cause: assert property (delimiter_pair_seen_q |-> // RL4
		$past(c_pair) && $past(c_ev)) else $error("pair without spacing");
	a_np_latched: assert property (arb_q != AR_COMPLETE_ACK && // RL8
		arb_d == AR_COMPLETE_ACK |=>
		partner_next_page_latch_q == $past(m_page[NP_POS]))
		else $error("next page bit not latched");
	a_bad_toggle_hold: assert property (arb_q == AR_NEXT_WAIT && // RL14
		m_evt && !toggle_ok |=> arb_q == AR_NEXT_WAIT && !ack_bit_q)
		else $error("bad toggle acknowledged");
	a_single_ready: assert property (single_link_ready_q == // RL16
		$past(page_receiver_quiet &&
		(legacy_1g_link_ok ^ legacy_10g_link_ok)))
		else $error("single link ready wrong");
	a_toggle_first: assert property (first_np_q && arb_q != AR_NEXT_WAIT &&
		arb_d == AR_NEXT_WAIT |=> toggle_tx_q == // RL11
		!$past(local_page[TOGGLE_POS])) else $error("first toggle wrong");
	a_fault_restart: assert property (arb_q == AR_LINK_CHECK && // RL18
		!(legacy_1g_link_ok || legacy_10g_link_ok) |=>
		arb_q == AR_PD_FAULT ##1 arb_q == AR_ABILITY && page_tx_enable_q)
		else $error("no restart after fault");
endmodule : autoneg_rx_arb

// ### design/edge_classifier.sv
`timescale 1ns/1ps
module edge_classifier
	import autoneg_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              nrst,
	input  wire logic              edge_valid,
	input  wire logic [GAP_W-1:0]  edge_gap_ps,
	output logic                   ev_q,
	output logic                   short_q,
	output logic                   long_q,
	output logic                   half_q,
	output logic                   full_q,
	output logic                   pair_q
);
	logic mv_ok;
	logic prev_mv_q;

	assign mv_ok = (edge_gap_ps >= MV_PS - MV_TOL_PS) &&
		(edge_gap_ps <= MV_PS + MV_TOL_PS);

	// ----------------------------------------
	// Gap classes, one cycle after the edge
	// ----------------------------------------
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			ev_q      <= 1'b0;
			short_q   <= 1'b0;
			long_q    <= 1'b0;
			half_q    <= 1'b0;
			full_q    <= 1'b0;
			pair_q    <= 1'b0;
			prev_mv_q <= 1'b0;
		end else begin
			ev_q <= edge_valid;
			if (edge_valid) begin
				short_q   <= edge_gap_ps < SHORT_PS; // RL1
				long_q    <= edge_gap_ps > LONG_PS; // RL19
				half_q    <= (edge_gap_ps >= HALF_MIN_PS) &&
					(edge_gap_ps <= HALF_MAX_PS);
				full_q    <= (edge_gap_ps >= CLK_MIN_PS) &&
					(edge_gap_ps <= CLK_MAX_PS);
				pair_q    <= mv_ok && prev_mv_q; // RL4
				prev_mv_q <= mv_ok && !prev_mv_q;
			end
		end
	end
endmodule : edge_classifier

// ### design/page_matcher.sv
`timescale 1ns/1ps
module page_matcher
	import autoneg_pkg::*;
#(
	parameter int unsigned BITS = PAGE_BITS
) (
	input  wire logic            clock,
	input  wire logic            nrst,
	input  wire logic            page_valid,
	input  wire logic [BITS-1:0] page,
	output logic                 match_q,
	output logic [BITS-1:0]      page_q
);
	logic [5:0]      count_q;
	logic [BITS-1:0] ack_mask;
	logic            same;

	assign ack_mask = ~({{(BITS-1){1'b0}}, 1'b1} << ACK_POS);
	assign same     = ((page ^ page_q) & ack_mask) == '0;

	// ----------------------------------------
	// Consecutive consistent pages
	// ----------------------------------------
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			count_q <= 6'h00;
			page_q  <= '0;
			match_q <= 1'b0;
		end else begin
			match_q <= 1'b0;
			if (page_valid) begin
				page_q <= page;
				if (same && count_q != 6'h00) begin
					if (count_q < MATCH_COUNT) begin
						count_q <= count_q + 6'h01;
					end
					match_q <= count_q + 6'h01 >= MATCH_COUNT; // RL20
				end else begin
					count_q <= 6'h01;
				end
			end
		end
	end
endmodule : page_matcher

// ### include/autoneg_pkg.sv
package autoneg_pkg;
	// ----------------------------------------
	// Line timing in picoseconds
	// ----------------------------------------
	localparam int unsigned     GAP_W         = 16;
	localparam logic [15:0]     SHORT_PS      = 16'h0640; // 1600 ps
	localparam logic [15:0]     LONG_PS       = 16'h4E20; // 20000 ps
	localparam logic [15:0]     MV_PS         = 16'h3200; // 12800 ps
	localparam logic [15:0]     MV_TOL_PS     = 16'h00C8; // 200 ps
	localparam logic [15:0]     HALF_MIN_PS   = 16'h07D0; // 2000 ps
	localparam logic [15:0]     HALF_MAX_PS   = 16'h1130; // 4400 ps
	localparam logic [15:0]     CLK_MIN_PS    = 16'h12C0; // 4800 ps
	localparam logic [15:0]     CLK_MAX_PS    = 16'h1F40; // 8000 ps
	// ----------------------------------------
	// Page layout
	// ----------------------------------------
	localparam int unsigned     PAGE_BITS     = 48;
	localparam int unsigned     TOGGLE_POS    = 11;
	localparam int unsigned     ACK_POS       = 14;
	localparam int unsigned     NP_POS        = 15;
	localparam logic [5:0]      MATCH_COUNT   = 6'h03;
	localparam logic [3:0]      ACK_PAGES     = 4'h6;
	// ----------------------------------------
	// AXI4-Lite map
	// ----------------------------------------
	localparam logic [7:0]      OFS_LOCAL_LO  = 8'h00;
	localparam logic [7:0]      OFS_LOCAL_HI  = 8'h04;
	localparam logic [7:0]      OFS_STATUS    = 8'h08;
	localparam logic [7:0]      OFS_RX_LO     = 8'h0C;
	localparam logic [7:0]      OFS_RX_HI     = 8'h10;
	localparam logic [1:0]      RESP_OKAY     = 2'h0;
	localparam logic [1:0]      RESP_SLVERR   = 2'h2;
	localparam logic [31:0]     LOCAL_LO_RST  = 32'h0000_0000;
	localparam logic [15:0]     LOCAL_HI_RST  = 16'h0000;
	// ----------------------------------------
	// State machines
	// ----------------------------------------
	typedef enum logic [1:0] {
		RX_IDLE, RX_DELIM, RX_CLOCK, RX_DATA1
	} rx_state_t;
	typedef enum logic [2:0] {
		AR_ABILITY, AR_ACK_DETECT, AR_COMPLETE_ACK, AR_NEXT_WAIT,
		AR_GOOD_CHECK, AR_LINK_CHECK, AR_PD_FAULT
	} arb_state_t;
endpackage : autoneg_pkg

// ### tb/backplane_autoneg_rx_arbitration_flags_tb_top.sv
`timescale 1ns/1ps
module backplane_autoneg_rx_arbitration_flags_tb_top;
	import autoneg_pkg::*;
	localparam int unsigned HOLD = 8;
	logic clock, nrst, edge_valid, tx_page_done;
	logic legacy_1g_link_ok, legacy_10g_link_ok;
	logic [GAP_W-1:0] edge_gap_ps;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic ack_bit_q, toggle_tx_q, page_tx_enable_q, link_signaling_q;
	logic [PAGE_BITS-1:0] acc_q[$];
	logic [PAGE_BITS-1:0] rnd;
	logic [PAGE_BITS-1:0] exp_pg;
	int error_cnt = 0;
	int n_checks = 0;
	int m;
	link_partner_model lp (.clock(clock), .edge_valid(edge_valid),
		.edge_gap_ps(edge_gap_ps));
	autoneg_rx_arb #(.LINK_HOLD_CYCLES(HOLD)) uut (
		.clock(clock), .nrst(nrst), .edge_valid(edge_valid),
		.edge_gap_ps(edge_gap_ps), .tx_page_done(tx_page_done),
		.legacy_1g_link_ok(legacy_1g_link_ok),
		.legacy_10g_link_ok(legacy_10g_link_ok),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .ack_bit_q(ack_bit_q),
		.toggle_tx_q(toggle_tx_q), .page_tx_enable_q(page_tx_enable_q),
		.link_signaling_q(link_signaling_q));
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	// ----
	// Helpers
	// ----
	task close_out;
		$display("checks=%0d errors=%0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : close_out
	task chk(input logic [47:0] got, input logic [47:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task do_reset;
		@(posedge clock);
		nrst <= 1'b0;
		repeat (5) @(posedge clock);
		nrst <= 1'b1;
		acc_q.delete();
	endtask : do_reset
	task axi_wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clock);
			if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
			if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		rr = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (n == 50) begin
			error_cnt++;
			close_out;
		end
	endtask : axi_wr
	task axi_rd(input logic [7:0] a);
		int n;
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clock);
			if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		rd = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (n == 50) begin
			error_cnt++;
			close_out;
		end
	endtask : axi_rd
	function automatic logic [47:0] mk(input logic np, ack, tog);
		mk = rnd;
		mk[15] = np;
		mk[14] = ack;
		mk[11] = tog;
	endfunction : mk
	function automatic logic model_match;
		int k;
		logic [47:0] w;
		k = acc_q.size();
		w = 48'hFFFF_FFFF_BFFF;
		if (k < 3) return 1'b0;
		return ((acc_q[k-1] & w) == (acc_q[k-2] & w)) &&
			((acc_q[k-2] & w) == (acc_q[k-3] & w));
	endfunction : model_match
	task feed(input logic [47:0] p, input int mode);
		lp.send_page(p, mode);
		if (mode < 2) acc_q.push_back(p);
	endtask : feed
	task round(input logic [47:0] p);
		int i;
		for (i = 0; i < 6; i++) begin
			if (i == 3) p[14] = 1'b1;
			feed(p, 0);
		end
		lp.close_page();
		repeat (6) @(posedge clock);
		for (i = 0; i < 6; i++) begin
			@(posedge clock);
			tx_page_done <= 1'b1;
			@(posedge clock);
			tx_page_done <= 1'b0;
		end
		repeat (4) @(posedge clock);
	endtask : round
	// ----
	// Main sequence
	// ----
	initial begin
		{nrst, tx_page_done, legacy_1g_link_ok, legacy_10g_link_ok} = 4'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hF;
		void'($urandom(16));
		rnd = 48'({$urandom(), $urandom()});
		repeat (5) @(posedge clock);
		nrst <= 1'b1;
		axi_rd(OFS_LOCAL_HI);
		chk({rr, rd}, {RESP_OKAY, 16'h0000, LOCAL_HI_RST});
		axi_wr(OFS_LOCAL_HI, 32'hFFFF_ABCD);
		axi_rd(OFS_LOCAL_HI);
		chk({rr, rd}, {RESP_OKAY, 32'h0000_ABCD});
		axi_wr(OFS_STATUS, 32'hFFFF_FFFF);
		chk(rr, RESP_SLVERR);
		axi_rd(8'h20);
		chk({rr, rd}, {RESP_SLVERR, 32'h0000_0000});
		for (m = 1; m < 5; m++) begin
			do_reset;
			feed(mk(0, 0, 0), m);
			feed(mk(0, 0, 0), 0);
			feed(mk(0, 0, 0), 0);
			lp.close_page();
			repeat (6) @(posedge clock);
			chk(ack_bit_q, model_match());
		end
		do_reset;
		axi_wr(OFS_LOCAL_LO, 32'h0000_8000);
		round(mk(1, 0, 0));
		axi_rd(OFS_STATUS);
		chk({rd[12:10], rd[4]}, 4'h7);
		chk(toggle_tx_q, 1);
		exp_pg = mk(1, 1, 0);
		axi_rd(OFS_RX_LO);
		chk({rr, rd}, {RESP_OKAY, exp_pg[31:0]});
		axi_rd(OFS_RX_HI);
		chk({rr, rd}, {RESP_OKAY, 16'h0000, exp_pg[47:32]});
		for (m = 0; m < 3; m++) feed(mk(0, 0, 0), 0);
		lp.close_page();
		repeat (6) @(posedge clock);
		chk({ack_bit_q, page_tx_enable_q, link_signaling_q}, 3'h2);
		round(mk(0, 0, 1));
		axi_rd(OFS_STATUS);
		chk(rd[6], 1);
		chk(toggle_tx_q, 0);
		axi_wr(OFS_LOCAL_LO, 32'h0000_0000);
		round(mk(0, 0, 0));
		chk({page_tx_enable_q, link_signaling_q}, 2'h1);
		for (m = 0; m < 2; m++) begin
			do_reset;
			legacy_1g_link_ok <= (m == 0);
			legacy_10g_link_ok <= (m == 1);
			repeat (3) @(posedge clock);
			{legacy_1g_link_ok, legacy_10g_link_ok} <= 2'h0;
			repeat (6) @(posedge clock);
			chk({page_tx_enable_q, link_signaling_q}, 2'h2);
			legacy_1g_link_ok <= (m == 0);
			legacy_10g_link_ok <= (m == 1);
			repeat (HOLD + 12) @(posedge clock);
			chk({page_tx_enable_q, link_signaling_q}, 2'h1);
			{legacy_1g_link_ok, legacy_10g_link_ok} <= 2'h0;
		end
		do_reset;
		{legacy_1g_link_ok, legacy_10g_link_ok} <= 2'h3;
		repeat (HOLD + 12) @(posedge clock);
		chk(link_signaling_q, 0);
		close_out;
	end
	initial begin
		repeat (90000) @(posedge clock);
		error_cnt++;
		close_out;
	end
endmodule : backplane_autoneg_rx_arbitration_flags_tb_top

// ### tb/link_partner_model.sv
`timescale 1ns/1ps
// ----
// Link partner page sender
// ----
module link_partner_model
	import autoneg_pkg::*;
(
	input  wire logic        clock,
	output logic             edge_valid,
	output logic [GAP_W-1:0] edge_gap_ps
);
	initial begin
		edge_valid = 1'b0;
		edge_gap_ps = 16'h0000;
	end
	task put_edge(input logic [GAP_W-1:0] g);
		@(posedge clock);
		edge_valid <= 1'b1;
		edge_gap_ps <= g;
	endtask : put_edge
	// Modes: 1 short mid page, 2 bad pair, 3 short, 4 long
	task send_page(input logic [PAGE_BITS-1:0] p, input int mode);
		int i;
		put_edge(mode == 2 ? 16'h36B0 : MV_PS);
		put_edge(mode == 2 ? 16'h36B0 : MV_PS);
		if (mode == 3) put_edge(16'h03E8);
		if (mode == 4) put_edge(16'h5DC0);
		put_edge(16'h1900); // Leading clock edge
		for (i = 0; i < PAGE_BITS; i++) begin
			if (mode == 1 && i == 20) put_edge(16'h03E8);
			if (p[i]) begin
				put_edge(16'h0C80);
				put_edge(16'h0C80);
			end else begin
				put_edge(16'h1900);
			end
		end
	endtask : send_page
	task close_page;
		put_edge(MV_PS);
		put_edge(MV_PS);
		@(posedge clock);
		edge_valid <= 1'b0;
		edge_gap_ps <= ~edge_gap_ps;
	endtask : close_page
endmodule : link_partner_model
